// *** rtl/amtr_pkg.sv ***
// Constants and types of the converter mode and output test register bank
package amtr_pkg;

	// Register offsets on the serial control port
	localparam logic [7:0] AMTR_OFS_MODE = 8'h08;
	localparam logic [7:0] AMTR_OFS_CLOCK = 8'h09;
	localparam logic [7:0] AMTR_OFS_TEST = 8'h0D;

	// Reset values
	localparam logic [7:0] AMTR_RST_MODE = 8'h00;
	localparam logic [7:0] AMTR_RST_CLOCK = 8'h01;
	localparam logic [7:0] AMTR_RST_TEST = 8'h00;

	// Field positions
	localparam int AMTR_MODE_LSB = 0;
	localparam int AMTR_MODE_W = 3;
	localparam int AMTR_DCS_BIT = 0;
	localparam int AMTR_TEST_LSB = 0;
	localparam int AMTR_TEST_W = 4;
	localparam int AMTR_PNS_RST_BIT = 4;
	localparam int AMTR_PNL_RST_BIT = 5;

	// Channel count and sample width
	localparam int AMTR_NCH = 8;
	localparam int AMTR_DW = 12;

	// Pseudo-random generators: polynomial length and feedback tap
	localparam int AMTR_PNL_LEN = 23;
	localparam int AMTR_PNL_TAP = 18;
	localparam int AMTR_PNS_LEN = 9;
	localparam int AMTR_PNS_TAP = 5;

	// Fixed test words, offset binary
	localparam logic [11:0] AMTR_W_MIDSCALE = 12'h800;
	localparam logic [11:0] AMTR_W_POS_FS = 12'hFFF;
	localparam logic [11:0] AMTR_W_CHECK_A = 12'hAAA;
	localparam logic [11:0] AMTR_W_CHECK_B = 12'h555;
	localparam logic [11:0] AMTR_W_ONES = 12'hFFF;
	localparam logic [11:0] AMTR_W_ZEROS = 12'h000;
	localparam logic [11:0] AMTR_W_BIT_TOGGLE = 12'h555;
	localparam logic [11:0] AMTR_W_SYNC = 12'hFC0;
	localparam logic [11:0] AMTR_W_ONE_HIGH = 12'h800;
	localparam logic [11:0] AMTR_W_MIXED = 12'hA33;
	localparam logic [11:0] AMTR_W_TWOS_FLIP = 12'h800;

	typedef enum logic [2:0] {
		AMTR_PM_RUN = 3'b000,
		AMTR_PM_FULL_DOWN = 3'b001,
		AMTR_PM_STANDBY = 3'b010,
		AMTR_PM_RESET = 3'b011,
		AMTR_PM_CONT_WAVE = 3'b100
	} amtr_pwr_t;

	typedef enum logic [3:0] {
		AMTR_TM_OFF = 4'b0000,
		AMTR_TM_MIDSCALE = 4'b0001,
		AMTR_TM_POS_FS = 4'b0010,
		AMTR_TM_CHECKER = 4'b0100,
		AMTR_TM_RAND_LONG = 4'b0101,
		AMTR_TM_RAND_SHORT = 4'b0110,
		AMTR_TM_WORD_TOGGLE = 4'b0111,
		AMTR_TM_USER = 4'b1000,
		AMTR_TM_BIT_TOGGLE = 4'b1001,
		AMTR_TM_SYNC = 4'b1010,
		AMTR_TM_ONE_HIGH = 4'b1011,
		AMTR_TM_MIXED = 4'b1100
	} amtr_test_t;

endpackage

// *** rtl/amtr_prbs.sv ***
// Pseudo-random word generator, twelve bits advanced per sample
module amtr_prbs #(
	parameter int LEN = 9,
	parameter int TAP = 5
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// Hold in seed state while high
	input wire logic hold,
	// Current word
	output logic [11:0] word
);
	logic [LEN-1:0] state;
	logic [LEN-1:0] next_state;
	logic [11:0] next_word;

	// Twelve Fibonacci steps in one clock
	always_comb begin
		next_state = state;
		next_word = '0;
		for (int i = 0; i < 12; i++) begin
			next_word = {next_word[10:0], next_state[LEN-1]};
			next_state = {next_state[LEN-2:0], next_state[LEN-1] ^ next_state[TAP-1]};
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state <= '1;
			word <= '0;
		end else if (hold) begin
			state <= '1;
			word <= '0;
		end else begin
			state <= next_state;
			word <= next_word;
		end
	end
endmodule // amtr_prbs

// *** rtl/amtr_pattern.sv ***
// Per-channel test word selection
module amtr_pattern (
	// Selection
	input wire logic [3:0] code,
	input wire logic phase,
	input wire logic fmt_twos,
	// Sources
	input wire logic [11:0] sample,
	input wire logic [11:0] pseudo_random_long,
	input wire logic [11:0] pseudo_random_short,
	input wire logic [11:0] user_pattern,
	// Result
	output logic [11:0] word
);
	wire [11:0] mixed_word = fmt_twos ? (amtr_pkg::AMTR_W_MIXED ^ amtr_pkg::AMTR_W_TWOS_FLIP)
		: amtr_pkg::AMTR_W_MIXED;
	wire [11:0] checker_word = phase ? amtr_pkg::AMTR_W_CHECK_B : amtr_pkg::AMTR_W_CHECK_A;
	wire [11:0] toggle_word = phase ? amtr_pkg::AMTR_W_ZEROS : amtr_pkg::AMTR_W_ONES;

	always_comb begin
		case (code)
			amtr_pkg::AMTR_TM_MIDSCALE: word = amtr_pkg::AMTR_W_MIDSCALE;
			amtr_pkg::AMTR_TM_POS_FS: word = amtr_pkg::AMTR_W_POS_FS;
			amtr_pkg::AMTR_TM_CHECKER: word = checker_word;
			amtr_pkg::AMTR_TM_RAND_LONG: word = pseudo_random_long;
			amtr_pkg::AMTR_TM_RAND_SHORT: word = pseudo_random_short;
			amtr_pkg::AMTR_TM_WORD_TOGGLE: word = toggle_word;
			amtr_pkg::AMTR_TM_USER: word = user_pattern;
			amtr_pkg::AMTR_TM_BIT_TOGGLE: word = amtr_pkg::AMTR_W_BIT_TOGGLE;
			amtr_pkg::AMTR_TM_SYNC: word = amtr_pkg::AMTR_W_SYNC;
			amtr_pkg::AMTR_TM_ONE_HIGH: word = amtr_pkg::AMTR_W_ONE_HIGH;
			amtr_pkg::AMTR_TM_MIXED: word = mixed_word;
			default: word = sample;
		endcase
	end
endmodule // amtr_pattern

// *** rtl/amtr_regs.sv ***
// Chip mode, clock conditioning and output test register bank
module amtr_regs (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// Channel selection and shared settings
	input wire logic [7:0] chan_sel,
	input wire logic fmt_twos,
	input wire logic [11:0] user_pattern,
	// Sample path
	input wire logic [95:0] sample_in,
	output logic [95:0] data_out,
	// Mode outputs and clock stabilizer enable
	output logic full_power_down,
	output logic standby,
	output logic chip_reset_req,
	output logic continuous_wave,
	output logic time_gain_path_off,
	output logic dcs_enable
);
	logic [2:0] mode;
	logic dcs;
	logic pnl_rst;
	logic pns_rst;
	logic [3:0] test_code [amtr_pkg::AMTR_NCH];
	logic phase;
	logic [11:0] pseudo_random_long;
	logic [11:0] pseudo_random_short;
	logic [95:0] next_data;

	function automatic logic is_mode(input logic [2:0] m, input amtr_pkg::amtr_pwr_t c);
		is_mode = (m == c);
	endfunction

	function automatic logic [2:0] first_sel(input logic [7:0] sel);
		first_sel = 3'h0;
		for (int i = 7; i >= 0; i--) begin
			if (sel[i]) begin
				first_sel = i[2:0];
			end
		end
	endfunction

	// Address decode
	wire hit_mode = (reg_addr == amtr_pkg::AMTR_OFS_MODE);
	wire hit_clock = (reg_addr == amtr_pkg::AMTR_OFS_CLOCK);
	wire hit_test = (reg_addr == amtr_pkg::AMTR_OFS_TEST);
	wire wr_mode = reg_wr && hit_mode;
	wire wr_clock = reg_wr && hit_clock;
	wire wr_test = reg_wr && hit_test;
	wire [2:0] rd_chan = first_sel(chan_sel);

	wire [7:0] rd_mode = {5'h00, mode};
	wire [7:0] rd_clock = {7'h00, dcs};
	wire [7:0] rd_test = {2'h0, pnl_rst, pns_rst, test_code[rd_chan]};
	wire [7:0] next_rdata = hit_mode ? rd_mode : hit_clock ? rd_clock : hit_test ? rd_test : 8'h00;

	// Mode decode; codes 101..111 fall through to run
	wire next_full_down = is_mode(mode, amtr_pkg::AMTR_PM_FULL_DOWN);
	wire next_standby = is_mode(mode, amtr_pkg::AMTR_PM_STANDBY);
	wire next_reset_req = is_mode(mode, amtr_pkg::AMTR_PM_RESET);
	wire next_cont_wave = is_mode(mode, amtr_pkg::AMTR_PM_CONT_WAVE);

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			mode <= amtr_pkg::AMTR_RST_MODE[amtr_pkg::AMTR_MODE_LSB +: amtr_pkg::AMTR_MODE_W];
		end else if (wr_mode) begin
			mode <= reg_wdata[amtr_pkg::AMTR_MODE_LSB +: amtr_pkg::AMTR_MODE_W];
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			dcs <= amtr_pkg::AMTR_RST_CLOCK[amtr_pkg::AMTR_DCS_BIT];
		end else if (wr_clock) begin
			dcs <= reg_wdata[amtr_pkg::AMTR_DCS_BIT];
		end
	end

	// Generator reset bits are global, so any test write updates them
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pnl_rst <= amtr_pkg::AMTR_RST_TEST[amtr_pkg::AMTR_PNL_RST_BIT];
			pns_rst <= amtr_pkg::AMTR_RST_TEST[amtr_pkg::AMTR_PNS_RST_BIT];
		end else if (wr_test) begin
			pnl_rst <= reg_wdata[amtr_pkg::AMTR_PNL_RST_BIT];
			pns_rst <= reg_wdata[amtr_pkg::AMTR_PNS_RST_BIT];
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			phase <= 1'b0;
		end else begin
			phase <= ~phase;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			reg_rdata <= next_rdata;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			full_power_down <= 1'b0;
			standby <= 1'b0;
			chip_reset_req <= 1'b0;
			continuous_wave <= 1'b0;
			time_gain_path_off <= 1'b0;
			dcs_enable <= amtr_pkg::AMTR_RST_CLOCK[amtr_pkg::AMTR_DCS_BIT];
		end else begin
			full_power_down <= next_full_down;
			standby <= next_standby;
			chip_reset_req <= next_reset_req;
			continuous_wave <= next_cont_wave;
			time_gain_path_off <= next_cont_wave;
			dcs_enable <= dcs;
		end
	end

	// One generator pair feeds every channel
	amtr_prbs #(
		.LEN(amtr_pkg::AMTR_PNL_LEN),
		.TAP(amtr_pkg::AMTR_PNL_TAP)
	) u_long_gen (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.hold(pnl_rst),
		.word(pseudo_random_long)
	);

	amtr_prbs #(
		.LEN(amtr_pkg::AMTR_PNS_LEN),
		.TAP(amtr_pkg::AMTR_PNS_TAP)
	) u_short_gen (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.hold(pns_rst),
		.word(pseudo_random_short)
	);

	for (genvar ch = 0; ch < amtr_pkg::AMTR_NCH; ch++) begin : g_chan
		always_ff @(posedge clk_sys or negedge rst_n) begin
			if (!rst_n) begin
				test_code[ch] <= amtr_pkg::AMTR_RST_TEST[amtr_pkg::AMTR_TEST_LSB +: amtr_pkg::AMTR_TEST_W];
			end else if (wr_test && chan_sel[ch]) begin
				test_code[ch] <= reg_wdata[amtr_pkg::AMTR_TEST_LSB +: amtr_pkg::AMTR_TEST_W];
			end
		end

		amtr_pattern u_pattern (
			.code(test_code[ch]),
			.phase(phase),
			.fmt_twos(fmt_twos),
			.sample(sample_in[ch*12 +: 12]),
			.pseudo_random_long(pseudo_random_long),
			.pseudo_random_short(pseudo_random_short),
			.user_pattern(user_pattern),
			.word(next_data[ch*12 +: 12])
		);
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			data_out <= '0;
		end else begin
			data_out <= next_data;
		end
	end

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);

	a_mode_full_down: assert property (wr_mode && reg_wdata[2:0] == 3'b001 |-> ##2 full_power_down && !standby)
		else $error("full power-down not reached two cycles after mode write");
	a_mode_standby: assert property (wr_mode && reg_wdata[2:0] == 3'b010 |-> ##2 standby && !full_power_down)
		else $error("standby not reached two cycles after mode write");
	a_mode_reset_req: assert property (wr_mode && reg_wdata[2:0] == 3'b011 |-> ##2 chip_reset_req)
		else $error("reset request missing after mode write");
	a_mode_wave_path: assert property (continuous_wave == time_gain_path_off)
		else $error("continuous wave and time gain path off disagree");
	a_mode_unlisted: assert property (wr_mode && reg_wdata[2] && reg_wdata[1:0] != 2'b00 |-> ##2
		!(full_power_down || standby || chip_reset_req || continuous_wave))
		else $error("unlisted mode code did not give normal running");
	a_dcs_follows: assert property (wr_clock |-> ##2 dcs_enable == $past(reg_wdata[0], 2))
		else $error("stabilizer enable does not follow clock register");
	a_test_normal: assert property (wr_test && chan_sel[0] && reg_wdata[3:0] == 4'h0 ##1 !(wr_test && chan_sel[0])
		|-> ##1 data_out[11:0] == $past(sample_in[11:0]))
		else $error("channel 0 not passing samples with test off");
	a_test_midscale: assert property (test_code[0] == 4'b0001 |-> ##1 data_out[11:0] == 12'h800)
		else $error("midscale word wrong on channel 0");
	a_test_toggle: assert property (test_code[0] == 4'b0111 ##1 test_code[0] == 4'b0111
		|-> ##1 data_out[11:0] == ~$past(data_out[11:0]))
		else $error("word toggle did not invert");
	a_long_gen_hold: assert property (pnl_rst [*2] |-> pseudo_random_long == 12'h000)
		else $error("long generator not held in reset");
	a_short_gen_hold: assert property (pns_rst [*2] |-> pseudo_random_short == 12'h000)
		else $error("short generator not held in reset");
	a_short_gen_shared: assert property (test_code[2] == 4'b0110 && test_code[5] == 4'b0110
		|-> ##1 data_out[35:24] == data_out[71:60])
		else $error("short sequence differs between channels");
	a_mixed_format: assert property (test_code[0] == 4'b1100 |-> ##1
		data_out[11:0] == ($past(fmt_twos) ? 12'h233 : 12'hA33))
		else $error("mixed frequency word ignores format");
	a_read_mode: assert property (reg_rd && hit_mode |-> ##1 reg_rdata == {5'h00, $past(mode)})
		else $error("mode register readback wrong");

	// Further mode and clock checks
	a_mode_wave_entry: assert property (wr_mode && reg_wdata[2:0] == 3'b100 |-> ##2 continuous_wave)
		else $error("continuous wave not reached after mode write");
	a_mode_run: assert property (wr_mode && reg_wdata[2:0] == 3'b000 |-> ##2
		!(full_power_down || standby || chip_reset_req || continuous_wave))
		else $error("run code did not clear the mode outputs");
	a_mode_exclusive: assert property ($onehot0({full_power_down, standby, chip_reset_req, continuous_wave}))
		else $error("more than one mode output active");
	a_mode_holds: assert property (!wr_mode |=> $stable(mode))
		else $error("mode field changed without a write");
	a_reset_req_level: assert property (chip_reset_req && !$past(wr_mode) |=> chip_reset_req)
		else $error("reset request dropped while its code is held");
	a_dcs_holds: assert property (!wr_clock |=> $stable(dcs))
		else $error("stabilizer bit changed without a write");
	a_dcs_output: assert property (dcs_enable == $past(dcs))
		else $error("stabilizer enable does not track its register bit");
	a_read_clock: assert property (reg_rd && hit_clock |-> ##1 reg_rdata == {7'h00, $past(dcs)})
		else $error("clock register readback wrong");

	// Pattern selection on channel 0, channel 7 code hold and long sequence shared by channels 0 and 1
	a_test_pos_fs: assert property (test_code[0] == 4'b0010 |-> ##1 data_out[11:0] == 12'hFFF)
		else $error("positive full-scale word wrong on channel 0");
	a_test_checker: assert property (test_code[0] == 4'b0100 |-> ##1
		data_out[11:0] == ($past(phase) ? 12'h555 : 12'hAAA))
		else $error("checkerboard word wrong on channel 0");
	a_test_long_seq: assert property (test_code[0] == 4'b0101 |-> ##1
		data_out[11:0] == $past(pseudo_random_long))
		else $error("long sequence not routed to channel 0");
	a_test_short_seq: assert property (test_code[0] == 4'b0110 |-> ##1
		data_out[11:0] == $past(pseudo_random_short))
		else $error("short sequence not routed to channel 0");
	a_test_user: assert property (test_code[0] == 4'b1000 |-> ##1 data_out[11:0] == $past(user_pattern))
		else $error("user word wrong on channel 0");
	a_test_bit_toggle: assert property (test_code[0] == 4'b1001 |-> ##1 data_out[11:0] == 12'h555)
		else $error("bit toggle word wrong on channel 0");
	a_test_sync: assert property (test_code[0] == 4'b1010 |-> ##1 data_out[11:0] == 12'hFC0)
		else $error("sync word wrong on channel 0");
	a_test_one_high: assert property (test_code[0] == 4'b1011 |-> ##1 data_out[11:0] == 12'h800)
		else $error("single high bit word wrong on channel 0");
	a_test_unlisted: assert property (test_code[0] == 4'b0011 || test_code[0] >= 4'b1101 |-> ##1
		data_out[11:0] == $past(sample_in[11:0]))
		else $error("unlisted test code did not pass samples");
	a_test_per_chan: assert property (!(wr_test && chan_sel[7]) |=> $stable(test_code[7]))
		else $error("channel 7 test code changed without its select bit");
	a_long_gen_shared: assert property (test_code[0] == 4'b0101 && test_code[1] == 4'b0101 |-> ##1
		data_out[11:0] == data_out[23:12])
		else $error("long sequence differs between channels");

	// Generators restart from the all-ones seed
	a_long_gen_seed: assert property (pnl_rst ##1 !pnl_rst |-> ##1 pseudo_random_long == 12'hFFF)
		else $error("long generator did not restart from its seed");
	a_short_gen_seed: assert property (pns_rst ##1 !pns_rst |-> ##1 pseudo_random_short == 12'hFF8)
		else $error("short generator did not restart from its seed");
	// Nine stages never repeat a twelve-bit window back to back
	a_short_gen_runs: assert property (!pns_rst ##1 !pns_rst |-> pseudo_random_short != $past(pseudo_random_short))
		else $error("short generator stalled while released");

	// Read port
	a_read_test: assert property (reg_rd && hit_test && chan_sel[0] |-> ##1
		reg_rdata == {2'h0, $past(pnl_rst), $past(pns_rst), $past(test_code[0])})
		else $error("test register readback wrong for channel 0");
	a_read_unmapped: assert property (reg_rd && !(hit_mode || hit_clock || hit_test) |-> ##1 reg_rdata == 8'h00)
		else $error("unmapped address did not read zero");
	a_read_holds: assert property (!reg_rd |=> $stable(reg_rdata))
		else $error("read data changed without a read");

	c_wave_entry: cover property (wr_mode && reg_wdata[2:0] == 3'b100 ##2 continuous_wave);
	c_long_gen_run: cover property (test_code[0] == 4'b0101 && !pnl_rst ##1 data_out[11:0] != 12'h000);
	c_mixed_twos: cover property (test_code[0] == 4'b1100 && fmt_twos);
	c_per_channel: cover property (test_code[0] != test_code[7]);
	c_chan_one_high: cover property (test_code[1] == 4'b1011 ##1 data_out[23:12] == 12'h800);
endmodule // amtr_regs

// *** verification/amtr_host.sv ***
// Host model driving the register strobes of the bank
module amtr_host (
	// Clock
	input wire logic clk_sys,
	// Register port
	output logic [7:0] reg_addr,
	output logic [7:0] reg_wdata,
	output logic reg_wr,
	output logic reg_rd,
	input wire logic [7:0] reg_rdata
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	end
	// One-cycle write pulse; strobes change only on falling edges
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge clk_sys);
		reg_wr = 1'b0;
		// Released data no longer shows the written value
		reg_wdata = ~d;
	endtask
	// Read data is settled half a cycle after the taking edge
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge clk_sys);
		reg_rd = 1'b0;
		d = reg_rdata;
	endtask
endmodule // amtr_host

// *** verification/test_adc_mode_test_registers.sv ***
// Self-checking bench of the mode and output test register bank
module test_adc_mode_test_registers;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, chan_sel, rd_val;
	logic reg_wr, reg_rd, fmt_twos;
	logic full_power_down, standby, chip_reset_req, continuous_wave, time_gain_path_off, dcs_enable;
	logic [11:0] user_pattern, tmp, e;
	logic [95:0] sample_in, data_out;
	logic [4:0] m;
	int n_errors = 0;
	int check_count = 0;
	logic [3:0] codes [10] = '{4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'hA, 4'hB, 4'hC, 4'hD, 4'hF};
	always #12.5 clk_sys = ~clk_sys;
	amtr_host u_host (.clk_sys(clk_sys), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata));
	amtr_regs u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .chan_sel(chan_sel), .fmt_twos(fmt_twos),
		.user_pattern(user_pattern), .sample_in(sample_in), .data_out(data_out),
		.full_power_down(full_power_down), .standby(standby), .chip_reset_req(chip_reset_req),
		.continuous_wave(continuous_wave), .time_gain_path_off(time_gain_path_off), .dcs_enable(dcs_enable));
	task automatic chk(input logic [11:0] g, input logic [11:0] x);
		check_count++;
		if (g !== x) begin
			n_errors++;
			$display("ERROR t=%0t got=%h exp=%h", $time, g, x);
		end
	endtask
	task automatic wrap_up();
		$display("checks=%0d errors=%0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic step(input int k);
		repeat (k) @(negedge clk_sys);
	endtask
	function automatic logic [11:0] ch(input int n);
		return data_out[12 * n +: 12];
	endfunction
	// Expected word of a fixed pattern code for a channel sample
	function automatic logic [11:0] exp_w(input logic [3:0] c, input logic f, input logic [11:0] s);
		case (c)
			4'h1: return amtr_pkg::AMTR_W_MIDSCALE;
			4'h2: return amtr_pkg::AMTR_W_POS_FS;
			4'h8: return user_pattern;
			4'h9: return amtr_pkg::AMTR_W_BIT_TOGGLE;
			4'hA: return amtr_pkg::AMTR_W_SYNC;
			4'hB: return amtr_pkg::AMTR_W_ONE_HIGH;
			4'hC: return f ? 12'h233 : amtr_pkg::AMTR_W_MIXED;
			default: return s;
		endcase
	endfunction
	initial begin
		chan_sel = 8'h01;
		fmt_twos = 1'b0;
		user_pattern = 12'h5C3;
		for (int n = 0; n < 8; n++) begin
			sample_in[12 * n +: 12] = 12'h120 + 12'(n);
		end
		step(10);
		rst_n = 1'b1;
		step(1);
		chk(12'(dcs_enable), 12'h001);
		u_host.rd(amtr_pkg::AMTR_OFS_MODE, rd_val);
		chk(12'(rd_val), 12'h000);
		u_host.rd(amtr_pkg::AMTR_OFS_CLOCK, rd_val);
		chk(12'(rd_val), 12'h001);
		u_host.rd(amtr_pkg::AMTR_OFS_TEST, rd_val);
		chk(12'(rd_val), 12'h000);
		u_host.rd(8'h0A, rd_val);
		chk(12'(rd_val), 12'h000);
		chk(ch(0), 12'h120);
		// Every mode code, with ignored upper bits set
		for (int c = 0; c < 8; c++) begin
			u_host.wr(amtr_pkg::AMTR_OFS_MODE, 8'hF8 | 8'(c));
			step(2);
			m = {full_power_down, standby, chip_reset_req, continuous_wave, time_gain_path_off};
			e = (c == 1) ? 12'h010 : (c == 2) ? 12'h008 : (c == 3) ? 12'h004 : (c == 4) ? 12'h003 : 12'h000;
			chk(12'(m), e);
			u_host.rd(amtr_pkg::AMTR_OFS_MODE, rd_val);
			chk(12'(rd_val), 12'(c));
		end
		u_host.wr(amtr_pkg::AMTR_OFS_CLOCK, 8'h00);
		step(2);
		chk(12'(dcs_enable), 12'h000);
		u_host.wr(amtr_pkg::AMTR_OFS_CLOCK, 8'h01);
		step(2);
		chk(12'(dcs_enable), 12'h001);
		// Fixed pattern and unlisted codes on channel 0 only, both formats
		for (int f = 0; f < 2; f++) begin
			fmt_twos = f[0];
			foreach (codes[i]) begin
				u_host.wr(amtr_pkg::AMTR_OFS_TEST, {4'h0, codes[i]});
				step(2);
				chk(ch(0), exp_w(codes[i], f[0], 12'h120));
				chk(ch(1), 12'h121);
			end
		end
		// Alternating patterns flip every sample
		for (int k = 0; k < 2; k++) begin
			u_host.wr(amtr_pkg::AMTR_OFS_TEST, k ? 8'h07 : 8'h04);
			step(2);
			tmp = ch(0);
			e = k ? amtr_pkg::AMTR_W_ONES : amtr_pkg::AMTR_W_CHECK_A;
			chk(12'(tmp === e || tmp === ~e), 12'h001);
			step(1);
			chk(ch(0), ~tmp);
		end
		// Channel 1 set apart, read back through its mask
		chan_sel = 8'h02;
		u_host.wr(amtr_pkg::AMTR_OFS_TEST, 8'h0B);
		u_host.rd(amtr_pkg::AMTR_OFS_TEST, rd_val);
		chk(12'(rd_val), 12'h00B);
		step(1);
		chk(ch(1), amtr_pkg::AMTR_W_ONE_HIGH);
		chk(ch(0), tmp);
		// Shared generators held, then running
		chan_sel = 8'h27;
		for (int k = 0; k < 2; k++) begin
			u_host.wr(amtr_pkg::AMTR_OFS_TEST, k ? 8'h16 : 8'h25);
			step(3);
			chk(ch(0), 12'h000);
			u_host.wr(amtr_pkg::AMTR_OFS_TEST, k ? 8'h06 : 8'h05);
			step(3);
			tmp = ch(0);
			chk(12'(tmp !== 12'h000), 12'h001);
			chk(ch(1), tmp);
			step(1);
			chk(12'(ch(0) !== tmp), 12'h001);
		end
		u_host.wr(amtr_pkg::AMTR_OFS_TEST, 8'h00);
		step(2);
		chk(ch(1), 12'h121);
		wrap_up();
	end
endmodule // test_adc_mode_test_registers
